// [src/gpp_regs.svh]
// gpp_regs.svh: register offsets, field widths and reset values of the port
// assumes: included by bare name from the port package and the port module
//
// Behaviour
// - mode field: 00 input, 01 output, 10 alternate function, 11 analog
// - pull field: 01 pull-up, 10 pull-down, 00 none; 11 reserved
// - output type 0 push-pull, 1 open-drain drives only low
// - output mode drives the pin from the output data bit
// - input data register samples every pin each clock cycle
// - after reset alternate functions idle, pins float, function select 0
// - debug pins reset to alternate function with their documented pulls
// - four-bit 16-way function select; pins 0-7 low, 8-15 high register
// - at most one peripheral function connected to a pin at once
// - enabled special functions override the standard pin configuration
// - registers accept word, half-word and byte accesses only
// - 16-bit output data read/write, input data read-only
// - set bit writes 1 sets output bit, reset bit clears it
// - zero written to set/reset register leaves output bits alone
// - set wins when one write both sets and clears a bit
// - set/reset acts once; direct output data writes always work
// - one set/reset write updates any bit mix atomically
// - output path can toggle a pin every two clock cycles
// - input mode ignores type and speed; pull 11 acts as no pull
// - speed field: x0 low, 01 medium, 11 high
// - correct lock sequence on bit 16 freezes flagged pins until reset
// - analog disables driver, pulls, input; input data reads 0

`ifndef GPP_REGS_SVH
`define GPP_REGS_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define GPP_OFF_MODE   8'h00
`define GPP_OFF_OTYPE  8'h04
`define GPP_OFF_SPEED  8'h08
`define GPP_OFF_PULL   8'h0c
`define GPP_OFF_IDR    8'h10
`define GPP_OFF_ODR    8'h14
`define GPP_OFF_BSC    8'h18
`define GPP_OFF_LOCK   8'h1c
`define GPP_OFF_AFL    8'h20
`define GPP_OFF_AFH    8'h24

// ----------------------------------------------------------------------------
// field layout and reset values
// ----------------------------------------------------------------------------
`define GPP_NPINS       16
`define GPP_NFUNC       16
`define GPP_LOCK_KEY    16
`define GPP_CLR_LSB     16
`define GPP_RST_MODE    32'ha800_0000
`define GPP_RST_SPEED   32'h0c00_0000
`define GPP_RST_PULL    32'h6400_0000
`define GPP_RST_ZERO    32'h0000_0000
`define GPP_SIZE_WORD   3'h2

`endif

// [src/gpp_pkg.sv]
// gpp_pkg.sv: types shared by the port logic
// assumes: gpp_regs.svh is on the include path

package gpp_pkg;
  `include "gpp_regs.svh"

  // pin mode codes
  typedef enum logic [1:0] {
    GPP_MODE_IN  = 2'h0,
    GPP_MODE_OUT = 2'h1,
    GPP_MODE_AF  = 2'h2,
    GPP_MODE_ANA = 2'h3
  } gpp_mode_e;

  // lock sequence states, gray along the path
  typedef enum logic [1:0] {
    GPP_LK_IDLE = 2'h0,
    GPP_LK_ONE  = 2'h1,
    GPP_LK_ZERO = 2'h3,
    GPP_LK_DONE = 2'h2
  } gpp_lock_e;

  // decoded drive strength per pin
  typedef enum logic [1:0] {
    GPP_SPD_LOW  = 2'h0,
    GPP_SPD_MED  = 2'h1,
    GPP_SPD_HIGH = 2'h2
  } gpp_speed_e;
endpackage : gpp_pkg

// [src/gpp_port.sv]
// gpp_port.sv: sixteen-pin port with alternate function multiplexer
// assumes: AHB-Lite slave on clk_i, pad inputs asynchronous to clk_i,
//          pad drivers and pull resistors built outside from the enables

`timescale 1ns/1ps
`default_nettype none

`include "gpp_regs.svh"

module gpp_port
  import gpp_pkg::*;
#(
  parameter logic [31:0] MODE_RST  = `GPP_RST_MODE,
  parameter logic [31:0] SPEED_RST = `GPP_RST_SPEED,
  parameter logic [31:0] PULL_RST  = `GPP_RST_PULL
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // AHB-Lite slave
  input  wire logic         hsel_i,
  input  wire logic [7:0]   haddr_i,
  input  wire logic [1:0]   htrans_i,
  input  wire logic         hwrite_i,
  input  wire logic [2:0]   hsize_i,
  input  wire logic [31:0]  hwdata_i,
  input  wire logic         hready_i,
  output logic [31:0]       hrdata_o,
  output logic              hreadyout_o,
  output logic              hresp_o,
  // pads
  input  wire logic [15:0]  pad_in_i,
  output logic [15:0]       pad_out_o,
  output logic [15:0]       pad_oe_o,
  output logic [15:0]       pull_up_o,
  output logic [15:0]       pull_down_o,
  output logic [15:0]       analog_en_o,
  output logic [31:0]       speed_o,
  // peripheral alternate functions, 16 per pin, pin-major
  input  wire logic [255:0] af_out_data_i,
  input  wire logic [255:0] af_out_en_i,
  output logic [255:0]      af_in_o,
  // special function override (clock, wake-up, oscillator)
  input  wire logic [15:0]  sf_en_i,
  input  wire logic [15:0]  sf_out_i,
  input  wire logic [15:0]  sf_oe_i
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  logic [31:0] mode_r, speed_r, pull_r, afl_r, afh_r;
  logic [15:0] otype_r, odr_r, idr_r, key_r;
  logic [15:0] sync1_r, sync2_r, sync3_r;
  gpp_lock_e   lock_r, lock_nxt;
  logic        dph_r, dwr_r;
  logic [7:0]  daddr_r;
  logic [3:0]  dbe_r;

  // --------------------------------------------------------------------------
  // AHB address phase and byte lanes
  // --------------------------------------------------------------------------
  wire        aph_go  = hsel_i & htrans_i[1] & hready_i;
  wire        sz_b    = (hsize_i == 3'h0);
  wire        sz_h    = (hsize_i == 3'h1);
  wire        sz_w    = (hsize_i == `GPP_SIZE_WORD);
  wire  [3:0] be_b    = 4'h1 << haddr_i[1:0];
  wire  [3:0] be_h    = haddr_i[1] ? 4'hc : 4'h3;
  // larger sizes select no lane and are ignored
  wire  [3:0] be_a    = sz_w ? 4'hf : (sz_h ? be_h : (sz_b ? be_b : 4'h0));

  // capture the address phase for the data phase
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dph_r   <= 1'b0;
      dwr_r   <= 1'b0;
      daddr_r <= 8'h00;
      dbe_r   <= 4'h0;
    end else if (hready_i) begin
      dph_r   <= aph_go;
      dwr_r   <= aph_go & hwrite_i;
      daddr_r <= {haddr_i[7:2], 2'h0};
      dbe_r   <= be_a;
    end
  end

  // zero wait states, never an error; unmapped reads as zero
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  // --------------------------------------------------------------------------
  // write decode and lane mask
  // --------------------------------------------------------------------------
  wire [31:0] wm      = {{8{dbe_r[3]}}, {8{dbe_r[2]}}, {8{dbe_r[1]}}, {8{dbe_r[0]}}};
  wire        we_mode = dwr_r & (daddr_r == `GPP_OFF_MODE);
  wire        we_otyp = dwr_r & (daddr_r == `GPP_OFF_OTYPE);
  wire        we_spd  = dwr_r & (daddr_r == `GPP_OFF_SPEED);
  wire        we_pull = dwr_r & (daddr_r == `GPP_OFF_PULL);
  wire        we_odr  = dwr_r & (daddr_r == `GPP_OFF_ODR);
  wire        we_bsc  = dwr_r & (daddr_r == `GPP_OFF_BSC);
  wire        we_lock = dwr_r & (daddr_r == `GPP_OFF_LOCK);
  wire        we_afl  = dwr_r & (daddr_r == `GPP_OFF_AFL);
  wire        we_afh  = dwr_r & (daddr_r == `GPP_OFF_AFH);

  // --------------------------------------------------------------------------
  // freeze masks from the lock key
  // --------------------------------------------------------------------------
  wire        locked  = (lock_r == GPP_LK_DONE);
  wire [15:0] frz1    = locked ? key_r : 16'h0000;
  logic [31:0] frz2;
  logic [63:0] frz4;
  always_comb begin
    for (int p = 0; p < `GPP_NPINS; p++) begin
      frz2[2*p +: 2] = {2{frz1[p]}};
      frz4[4*p +: 4] = {4{frz1[p]}};
    end
  end

  // lane merge leaving frozen bits untouched
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [31:0] m, input logic [31:0] frz);
    logic [31:0] k;
    k = m & ~frz;
    merge = (old & ~k) | (wd & k);
  endfunction : merge

  // --------------------------------------------------------------------------
  // configuration registers
  // --------------------------------------------------------------------------
  wire [31:0] mode_nxt  = we_mode ? merge(mode_r, hwdata_i, wm, frz2) : mode_r;
  wire [31:0] spd_nxt   = we_spd  ? merge(speed_r, hwdata_i, wm, frz2) : speed_r;
  wire [31:0] pull_nxt  = we_pull ? merge(pull_r, hwdata_i, wm, frz2) : pull_r;
  wire [31:0] otyp_full = merge({16'h0000, otype_r}, hwdata_i, wm, {16'h0000, frz1});
  wire [15:0] otyp_nxt  = we_otyp ? otyp_full[15:0] : otype_r;
  wire [31:0] afl_nxt   = we_afl  ? merge(afl_r, hwdata_i, wm, frz4[31:0]) : afl_r;
  wire [31:0] afh_nxt   = we_afh  ? merge(afh_r, hwdata_i, wm, frz4[63:32]) : afh_r;

  // reset leaves debug pins in their alternate function, select 0
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_r  <= MODE_RST;
      speed_r <= SPEED_RST;
      pull_r  <= PULL_RST;
      otype_r <= 16'h0000;
      afl_r   <= `GPP_RST_ZERO;
      afh_r   <= `GPP_RST_ZERO;
    end else begin
      mode_r  <= mode_nxt;
      speed_r <= spd_nxt;
      pull_r  <= pull_nxt;
      otype_r <= otyp_nxt;
      afl_r   <= afl_nxt;
      afh_r   <= afh_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // output data with set/clear port
  // --------------------------------------------------------------------------
  wire [15:0] bs_set  = we_bsc ? (hwdata_i[15:0] & wm[15:0]) : 16'h0000;
  wire [15:0] bs_clr  = we_bsc ? (hwdata_i[31:16] & wm[31:16]) : 16'h0000;
  wire [31:0] odr_mrg = merge({16'h0000, odr_r}, hwdata_i, wm, `GPP_RST_ZERO);
  wire [15:0] odr_dir = we_odr ? odr_mrg[15:0] : odr_r;
  // zeros change nothing, set beats clear, one write covers all bits
  wire [15:0] odr_nxt = (odr_dir & ~bs_clr) | bs_set;

  // one write per cycle lets a pin flip every second cycle or faster
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) odr_r <= 16'h0000;
    else          odr_r <= odr_nxt;
  end

  // --------------------------------------------------------------------------
  // lock sequence: key with bit 16 set, cleared, set again, same key
  // --------------------------------------------------------------------------
  wire        lk_word = we_lock & (dbe_r == 4'hf);
  wire        lk_same = (hwdata_i[15:0] == key_r);
  wire        lk_bit  = hwdata_i[`GPP_LOCK_KEY];

  // a wrong step drops back to idle
  always_comb begin
    lock_nxt = lock_r;
    case (lock_r)
      GPP_LK_IDLE: if (lk_word) lock_nxt = lk_bit ? GPP_LK_ONE : GPP_LK_IDLE;
      GPP_LK_ONE:  if (lk_word) lock_nxt = (!lk_bit && lk_same) ? GPP_LK_ZERO : GPP_LK_IDLE;
      GPP_LK_ZERO: if (lk_word) lock_nxt = (lk_bit && lk_same) ? GPP_LK_DONE : GPP_LK_IDLE;
      GPP_LK_DONE: lock_nxt = GPP_LK_DONE;
      default:     lock_nxt = GPP_LK_IDLE;
    endcase
  end

  // key follows word writes until the port locks
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lock_r <= GPP_LK_IDLE;
      key_r  <= 16'h0000;
    end else begin
      lock_r <= lock_nxt;
      if (lk_word && !locked) key_r <= hwdata_i[15:0];
    end
  end

  // --------------------------------------------------------------------------
  // read mux
  // --------------------------------------------------------------------------
  wire [31:0] rd_lock = {15'h0000, locked, key_r};
  always_comb begin
    hrdata_o = 32'h0000_0000;
    if (dph_r && !dwr_r) begin
      case (daddr_r)
        `GPP_OFF_MODE:  hrdata_o = mode_r;
        `GPP_OFF_OTYPE: hrdata_o = {16'h0000, otype_r};
        `GPP_OFF_SPEED: hrdata_o = speed_r;
        `GPP_OFF_PULL:  hrdata_o = pull_r;
        `GPP_OFF_IDR:   hrdata_o = {16'h0000, idr_r};
        `GPP_OFF_ODR:   hrdata_o = {16'h0000, odr_r};
        `GPP_OFF_LOCK:  hrdata_o = rd_lock;
        `GPP_OFF_AFL:   hrdata_o = afl_r;
        `GPP_OFF_AFH:   hrdata_o = afh_r;
        default:        hrdata_o = 32'h0000_0000;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // pad input synchroniser and input data capture
  // --------------------------------------------------------------------------
  logic [15:0] ana_v, out_v, af_v;
  wire  [15:0] stable  = ~(sync2_r ^ sync3_r);
  wire  [15:0] idr_nxt = ((stable & sync3_r) | (~stable & idr_r)) & ~ana_v;

  // sample every cycle; a change counts once stages two and three agree
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_r <= 16'h0000;
      sync2_r <= 16'h0000;
      sync3_r <= 16'h0000;
      idr_r   <= 16'h0000;
    end else begin
      sync1_r <= pad_in_i;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      idr_r   <= idr_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // per-pin mode, driver, pulls, speed and function multiplexer
  // --------------------------------------------------------------------------
  for (genvar i = 0; i < `GPP_NPINS; i++) begin : g_pin
    wire [1:0]  md   = mode_r[2*i +: 2];
    wire [1:0]  pc   = pull_r[2*i +: 2];
    wire [1:0]  sp   = speed_r[2*i +: 2];
    wire [3:0]  fsel = (i < 8) ? afl_r[4*(i%8) +: 4] : afh_r[4*(i%8) +: 4];
    wire        afd  = af_out_data_i[16*i + fsel];
    wire        afe  = af_out_en_i[16*i + fsel];
    wire        isou = (md == GPP_MODE_OUT);
    wire        isaf = (md == GPP_MODE_AF);
    wire        isan = (md == GPP_MODE_ANA);
    wire        dval = isou ? odr_r[i] : afd;
    wire        den  = isou | (isaf & afe);
    // open-drain drives only a low level
    wire        sdoe = den & (~otype_r[i] | ~dval);
    wire        sdo  = dval & ~otype_r[i];
    wire        dig  = ~isan & ~sf_en_i[i];

    assign ana_v[i]       = isan;
    assign out_v[i]       = isou;
    assign af_v[i]        = isaf;
    // special function takes the pin over
    assign pad_oe_o[i]    = sf_en_i[i] ? sf_oe_i[i] : sdoe;
    assign pad_out_o[i]   = sf_en_i[i] ? sf_out_i[i] : sdo;
    // reserved pull code gives no pull; analog drops both
    assign pull_up_o[i]   = dig & (pc == 2'h1);
    assign pull_down_o[i] = dig & (pc == 2'h2);
    assign analog_en_o[i] = isan & ~sf_en_i[i];
    // speed only matters while the pin can drive
    assign speed_o[2*i +: 2] = (!(isou | isaf) || !sp[0]) ? GPP_SPD_LOW :
                               (sp[1] ? GPP_SPD_HIGH : GPP_SPD_MED);

    // route the pin only to the one selected function
    for (genvar k = 0; k < `GPP_NFUNC; k++) begin : g_fn
      assign af_in_o[16*i + k] = isaf & (fsel == k) & idr_r[i];
    end

    af_onehot_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $onehot0(af_in_o[16*i +: 16]))
      else $error("pin routed to more than one function");

    // a pin that cannot drive reports low speed
    spd_idle_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !(isou || isaf) |-> speed_o[2*i +: 2] == GPP_SPD_LOW)
      else $error("speed reported on a pin that cannot drive");

    // reserved pull code enables neither resistor
    pull_rsvd_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      pc == 2'h3 |-> !pull_up_o[i] && !pull_down_o[i])
      else $error("reserved pull code enabled a pull");

    // peripheral enable, and in open-drain its data, set the driver enable of the selected pin
    af_drive_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      isaf && afe && !sf_en_i[i] |-> pad_oe_o[i] == (~otype_r[i] | ~afd))
      else $error("alternate function not driving its pin");
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  odr_set_win_a: assert property (we_bsc |=> ((odr_r & $past(bs_set)) == $past(bs_set)))
    else $error("set bit did not set output data");

  odr_clr_bit_a: assert property (we_bsc |=> ((odr_r & $past(bs_clr & ~bs_set)) == 16'h0))
    else $error("reset bit did not clear output data");

  bsc_zero_hold_a: assert property (we_bsc && !we_odr |=>
      (((odr_r ^ $past(odr_r)) & ~$past(bs_set | bs_clr)) == 16'h0))
    else $error("zero in set/reset changed output data");

  odr_direct_a: assert property (we_odr && dbe_r == 4'hf |=> odr_r == $past(hwdata_i[15:0]))
    else $error("direct output data write lost");

  idr_analog_a: assert property (ana_v != 16'h0 |=> (idr_r & $past(ana_v)) == 16'h0)
    else $error("analog pin read nonzero");

  idr_sample_a: assert property (stable == 16'hffff && ana_v == 16'h0 |=>
      idr_r == $past(sync3_r))
    else $error("input data missed pad level");

  od_no_high_a: assert property (((pad_oe_o & pad_out_o & otype_r & ~sf_en_i) == 16'h0))
    else $error("open-drain pin driven high");

  oe_mode_a: assert property (((pad_oe_o & ~(out_v | af_v | sf_en_i)) == 16'h0))
    else $error("driver on in input or analog mode");

  gp_out_data_a: assert property (((pad_oe_o & out_v & ~otype_r & ~sf_en_i)
      == (out_v & ~otype_r & ~sf_en_i)) &&
      (((pad_out_o ^ odr_r) & out_v & ~otype_r & ~sf_en_i) == 16'h0))
    else $error("output pin not following output data");

  pull_excl_a: assert property (((pull_up_o & pull_down_o) | ((pull_up_o | pull_down_o) & ana_v))
      == 16'h0)
    else $error("illegal pull combination");

  lock_freeze_a: assert property (locked |=> locked &&
      ((mode_r ^ $past(mode_r)) & $past(frz2)) == 32'h0)
    else $error("frozen configuration changed");

  lock_seq_a: assert property (lock_r == GPP_LK_ZERO && lk_word && lk_bit && lk_same
      |=> locked)
    else $error("correct lock sequence did not lock");

  // frozen output type bits hold as well
  otype_freeze_a: assert property (locked |=>
      ((otype_r ^ $past(otype_r)) & $past(frz1)) == 16'h0)
    else $error("frozen output type changed");

  // special function owns driver and value of its pin
  sf_override_a: assert property ((((pad_oe_o ^ sf_oe_i) | (pad_out_o ^ sf_out_i))
      & sf_en_i) == 16'h0)
    else $error("special function did not take the pin");

  // analog pins keep driver and pulls off
  ana_quiet_a: assert property ((analog_en_o & (pad_oe_o | pull_up_o | pull_down_o))
      == 16'h0)
    else $error("analog pin driven or pulled");

  // the set/clear register always reads back as zero
  bsc_read_a: assert property (dph_r && !dwr_r && daddr_r == `GPP_OFF_BSC |->
      hrdata_o == 32'h0)
    else $error("set/clear register read nonzero");

endmodule : gpp_port

`default_nettype wire

// [verif/gpp_pad_model.sv]
// gpp_pad_model.sv: pins and board wiring outside the port
// assumes: one clock shared with the port; bench drives ext_* at clock edges
`timescale 1ns/1ps
`default_nettype none
module gpp_pad_model (
  // port side
  input  wire logic        clk_i,
  input  wire logic [15:0] out_i,
  input  wire logic [15:0] oe_i,
  input  wire logic [15:0] pu_i,
  input  wire logic [15:0] pd_i,
  // board side
  input  wire logic [15:0] ext_en_i,
  input  wire logic [15:0] ext_i,
  output logic [15:0]      pin_o
);
  // an undriven pin without pull wanders every cycle, never a steady guess
  logic [15:0] flt_r = 16'h5aa5;
  always @(posedge clk_i) flt_r <= ~flt_r;
  // port driver first; released or open-drain high leaves board and pulls
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (oe_i[i]) pin_o[i] = out_i[i];
      else if (ext_en_i[i]) pin_o[i] = ext_i[i];
      else if (pu_i[i]) pin_o[i] = 1'b1;
      else if (pd_i[i]) pin_o[i] = 1'b0;
      else pin_o[i] = flt_r[i];
    end
  end
endmodule : gpp_pad_model
`default_nettype wire

// [verif/tb_gpio_port_with_af_mux.sv]
// tb_gpio_port_with_af_mux.sv: self-checking bench for the sixteen-pin port
// assumes: gpp_pkg compiled first; pins resolved by gpp_pad_model
`timescale 1ns/1ps
`default_nettype none
module tb_gpio_port_with_af_mux;
  import gpp_pkg::*;
  // ----------
  // signals
  // ----------
  logic         clk_i = 1'b0, rst_n_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0;
  logic         hready_i = 1'b1, hreadyout_o, hresp_o;
  logic [7:0]   haddr_i = 8'h00;
  logic [1:0]   htrans_i = 2'h0;
  logic [2:0]   hsize_i = 3'h2;
  logic [31:0]  hwdata_i = 32'h0, hrdata_o, speed_o, v, q;
  logic [15:0]  sf_en_i = 16'h0, sf_out_i = 16'h0, sf_oe_i = 16'h0;
  logic [15:0]  ext_en = 16'h0, ext_val = 16'h0, odr_m = 16'h0;
  logic [15:0]  pad_in, pad_out_o, pad_oe_o, pull_up_o, pull_down_o, analog_en_o;
  logic [255:0] af_out_data_i = '0, af_out_en_i = 256'h1, af_in_o;
  int           failures = 0;
  int           comparisons = 0;

  always #5 clk_i = ~clk_i;

  gpp_port i_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .pad_in_i(pad_in), .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o), .pull_up_o(pull_up_o),
    .pull_down_o(pull_down_o), .analog_en_o(analog_en_o), .speed_o(speed_o),
    .af_out_data_i(af_out_data_i), .af_out_en_i(af_out_en_i), .af_in_o(af_in_o),
    .sf_en_i(sf_en_i), .sf_out_i(sf_out_i), .sf_oe_i(sf_oe_i));
  gpp_pad_model i_pads (
    .clk_i(clk_i), .out_i(pad_out_o), .oe_i(pad_oe_o), .pu_i(pull_up_o),
    .pd_i(pull_down_o), .ext_en_i(ext_en), .ext_i(ext_val), .pin_o(pad_in));

  // ----------
  // tasks
  // ----------
  // compare and count
  task automatic chk_pin(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_pin
  // one transfer: address phase, then data phase where read data is taken
  task automatic bus(input logic [7:0] a, input logic w, input logic [2:0] sz,
                     input logic [31:0] d);
    @(posedge clk_i);
    hsel_i   <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i  <= a;
    hwrite_i <= w;
    hsize_i  <= sz;
    @(posedge clk_i);
    hsel_i   <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    #1;
    q = hrdata_o;
  endtask : bus
  // let one edge land
  task automatic settle();
    @(posedge clk_i);
    #1;
  endtask : settle
  // write, then wait until the register holds the new value
  task automatic wr(input logic [7:0] a, input logic [2:0] sz, input logic [31:0] d);
    bus(a, 1'b1, sz, d);
    settle();
  endtask : wr
  // word read compared with the bench model, plus the always-okay response
  task automatic chk_reg(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 3'h2, 32'h0);
    chk_pin(what, exp, q);
    chk_pin("response", 32'h2, {30'h0, hreadyout_o, hresp_o});
  endtask : chk_reg
  // verdict
  task automatic finish_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  // watchdog well beyond the roughly 170 cycles the sequence needs
  initial begin
    repeat (5000) @(posedge clk_i);
    failures++;
    finish_test();
  end

  // ----------
  // sequence
  // ----------
  initial begin
    void'($urandom(32'hb497));
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    settle();
    // reset state: debug pins alternate with their pulls, others float, function 0
    chk_reg("mode", 8'h00, 32'ha800_0000);
    chk_reg("pull", 8'h0c, 32'h6400_0000);
    chk_reg("af low", 8'h20, 32'h0);
    chk_reg("unmapped", 8'h40, 32'h0);
    chk_pin("pull up", {16'h0, pull_up_o}, 32'ha000);
    chk_pin("pull down", {16'h0, pull_down_o}, 32'h4000);
    chk_pin("drivers", {16'h0, pad_oe_o}, 32'h0);
    // every mode code on pin 0, whose function 0 asks to drive
    for (int m = 0; m < 4; m++) begin
      wr(8'h00, 3'h0, 32'(m));
      v = {30'h0, m == 1 || m == 2, m == 3};
      chk_pin("mode decode", v, {30'h0, pad_oe_o[0], analog_en_o[0]});
    end
    // by half-words: 0-7 output, 8-11 input, 12 analog, 13-15 alternate
    wr(8'h00, 3'h1, 32'h0000_5555);
    wr(8'h02, 3'h1, 32'hab00_0000);
    chk_reg("mode", 8'h00, 32'hab00_5555);
    odr_m = 16'($urandom);
    wr(8'h14, 3'h2, {16'h0, odr_m});
    chk_pin("pad out", {24'h0, odr_m[7:0]}, {24'h0, pad_out_o[7:0]});
    chk_pin("pad enable", 32'hff, {16'h0, pad_oe_o});
    chk_reg("output data", 8'h14, {16'h0, odr_m});
    // set/clear: overlapping set and clear first, then random mixes
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 32'h00ff_0f0f : $urandom;
      odr_m = (odr_m & ~v[31:16]) | v[15:0];
      wr(8'h18, 3'h2, v);
      chk_reg("output data", 8'h14, {16'h0, odr_m});
      chk_reg("set clear", 8'h18, 32'h0);
    end
    // a direct byte write still takes effect after set/clear use
    wr(8'h14, 3'h0, 32'h0000_00a5);
    odr_m[7:0] = 8'ha5;
    chk_reg("output data", 8'h14, {16'h0, odr_m});
    // back-to-back set then clear: pin 2, already high from the byte write, falls on the edge two cycles after the set
    bus(8'h18, 1'b1, 3'h2, 32'h0000_0004);
    bus(8'h18, 1'b1, 3'h2, 32'h0004_0000);
    chk_pin("toggle high", 32'h1, {31'h0, pad_out_o[2]});
    settle();
    chk_pin("toggle low", 32'h0, {31'h0, pad_out_o[2]});
    odr_m[2] = 1'b0;
    // board drives every pin the port leaves free; analog pin reads 0
    @(posedge clk_i);
    ext_en  <= 16'hff00;
    ext_val <= 16'($urandom);
    repeat (5) settle();
    v = {16'h0, ext_val[15:13], 1'b0, ext_val[11:8], odr_m[7:0]};
    chk_reg("input data", 8'h10, v);
    wr(8'h10, 3'h2, ~v);
    chk_reg("input data", 8'h10, v);
    // pulls: pin 8 up, 9 down, 10 reserved, 12 analog asks up
    wr(8'h0c, 3'h2, 32'h6539_0000);
    chk_pin("pull up", {16'h0, pull_up_o}, 32'ha100);
    chk_pin("pull down", {16'h0, pull_down_o}, 32'h4200);
    // open-drain pin 0: high releases, low drives
    wr(8'h04, 3'h2, 32'h0000_0001);
    wr(8'h18, 3'h2, 32'h0000_0001);
    chk_pin("open drain high", 32'h0, {31'h0, pad_oe_o[0]});
    wr(8'h18, 3'h2, 32'h0001_0000);
    chk_pin("open drain low", 32'h2, {30'h0, pad_oe_o[0], pad_out_o[0]});
    odr_m[0] = 1'b0;
    // speed codes on output, alternate and input pins
    wr(8'h08, 3'h2, 32'h0c03_0027);
    chk_pin("speed", 32'h0800_0006, speed_o);
    // special function takes pin 3 away from its output setting
    @(posedge clk_i);
    sf_en_i  <= 16'h0008;
    sf_out_i <= {12'h0, ~odr_m[3], 3'h0};
    settle();
    chk_pin("special", {31'h0, ~odr_m[3]}, {30'h0, pad_oe_o[3], pad_out_o[3]});
    // peripheral pins: function select of pins 1 and 14, then mode of pins 0-3
    @(posedge clk_i);
    for (int k = 0; k < 8; k++) af_out_data_i[32*k +: 32] <= $urandom;
    af_out_en_i <= '1;
    wr(8'h20, 3'h0, 32'h0000_0050);
    wr(8'h27, 3'h0, 32'h0300_0000);
    wr(8'h00, 3'h0, 32'h0000_0059);
    repeat (5) settle();
    v = {30'h0, af_out_data_i[21], af_out_data_i[227]};
    chk_pin("af out", v, {30'h0, pad_out_o[1], pad_out_o[14]});
    chk_pin("af in", {10'h0, af_out_data_i[21], 21'h0}, af_in_o[31:0]);
    // freeze pin 0, then try to move pins 0-3 back to input
    wr(8'h1c, 3'h2, 32'h0001_0001);
    wr(8'h1c, 3'h2, 32'h0000_0001);
    wr(8'h1c, 3'h2, 32'h0001_0001);
    chk_reg("lock", 8'h1c, 32'h0001_0001);
    wr(8'h00, 3'h0, 32'h0);
    chk_reg("mode", 8'h00, 32'hab00_5501);
    finish_test();
  end
endmodule : tb_gpio_port_with_af_mux
`default_nettype wire
